// ---- logic/ext_memory_space_decode.sv ----
// external program, local and global data decode onto two byte-wide srams
// How it works
// - two byte-wide 128K memories together give 128K words of 16-bit storage.
// - program takes 64K words, local data 32K, global data 32K.
// - drive active-low write and output enables and decode the addressed space.
// - accesses finish with no wait states requested from the processor.
// - microprocessor mode sends every program address to external program memory.
// - microcomputer mode enables external program memory only above 4000h.
// - microcomputer mode leaves program addresses up to 4000h to on-chip flash.
// - only data addresses 8000h-FFFFh reach external memory; lower ones never do.
// - global allocation register sits at data address 0005h, low eight data bits.
// - its value sets global space size from 256 words to 32K words.
// - low byte picks the range, high byte ignored; zero means no global space.
// - local and global words at one address live in separate memory.
module ext_memory_space_decode (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [mem_decode_pkg::ADDR_W-1:0] addr,
    input wire logic [mem_decode_pkg::DATA_W-1:0] data_in,
    input wire logic prog_strobe_n,
    input wire logic data_strobe_n,
    input wire logic io_strobe_n,
    input wire logic read_not_write,
    input wire logic write_strobe_n,
    input wire logic proc_mode_select,
    output logic [mem_decode_pkg::SRAM_ADDR_W-1:0] sram_addr,
    output logic sram_lo_cs_n,
    output logic sram_hi_cs_n,
    output logic sram_we_n,
    output logic sram_oe_n,
    output logic ready,
    output logic [7:0] global_alloc_reg,
    output logic [1:0] access_space
);
    import mem_decode_pkg::*;

    // every output is a register: address and strobes sampled at one edge
    // reach the memory pins after that edge, one cycle later, and no wait
    // state is ever asked of the processor. the mode strap is the only input
    // from outside the clock domain and passes two flip-flops first.
    // the processor's own bus signals share this clock and are read directly.
    // only one region is ever opened, so the two memories never fight.

    logic mode_meta;
    logic mode_sync;
    space_t space;
    space_t next_space;
    logic prog_space;
    logic data_space;
    logic above_flash;
    logic flash_owned;
    logic prog_hit;
    logic data_upper;
    logic data_ext;
    logic [7:0] mask_match;
    logic global_enabled;
    logic is_global;
    logic local_hit;
    logic global_hit;
    logic region_hit;
    logic [1:0] region;
    logic [14:0] data_word;
    logic read_cycle;
    logic write_cycle;
    logic global_alloc_reg_hit;
    logic global_alloc_reg_write;
    logic [7:0] global_alloc_reg_data;
    logic [SRAM_ADDR_W-1:0] next_sram_addr;
    logic next_cs_n;
    logic next_we_n;
    logic next_oe_n;

    // strobes are turned into one space code before any address decode
    space_classifier u_space (
        .prog_strobe_n(prog_strobe_n),
        .data_strobe_n(data_strobe_n),
        .io_strobe_n(io_strobe_n),
        .space(space)
    );

    // first stage may go metastable; only the second stage is read by logic
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_meta <= 1'b1;
        end else begin
            mode_meta <= proc_mode_select;
        end
    end

    // strap reads as microprocessor mode until the synchronised value lands
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_sync <= 1'b1;
        end else begin
            mode_sync <= mode_meta;
        end
    end

    // one decoded space per cycle, taken from the strobe classifier
    assign prog_space = (space == SPACE_PROG);
    assign data_space = (space == SPACE_DATA);
    assign next_space = space;

    // high mode_sync is microprocessor mode: all program space is external
    assign above_flash = (addr > FLASH_TOP_ADDR);
    // in microcomputer mode the on-chip flash answers up to and including 4000h
    assign flash_owned = !mode_sync && !above_flash;
    assign prog_hit = prog_space && !flash_owned;

    // the lower data half holds on-chip registers and never leaves the chip
    assign data_upper = (addr >= DATA_EXT_BASE);
    assign data_ext = data_space && data_upper;

    // each set register bit demands the matching upper address bit set
    for (genvar i = 0; i < 8; i++) begin : g_mask
        assign mask_match[i] = !global_alloc_reg[i] || addr[8 + i];
    end

    // a cleared low byte leaves the whole upper half local
    assign global_enabled = (global_alloc_reg != 8'h00);
    assign is_global = global_enabled && (&mask_match);
    assign global_hit = data_ext && is_global;
    assign local_hit = data_ext && !is_global;
    assign region_hit = prog_hit || local_hit || global_hit;

    // program uses 64K words, local and global each a separate 32K half
    assign region = global_hit ? REGION_GLOBAL : REGION_LOCAL;
    assign data_word = addr[14:0];
    assign next_sram_addr = prog_hit ? {1'b0, addr} : {region, data_word};

    // a write needs both the direction and the strobe; a read only direction
    assign read_cycle = read_not_write;
    assign write_cycle = !read_not_write && !write_strobe_n;
    assign next_cs_n = !region_hit;
    assign next_we_n = !(region_hit && write_cycle);
    assign next_oe_n = !(region_hit && read_cycle);

    // the allocation register decodes below 8000h, so it never opens a memory
    assign global_alloc_reg_hit = data_space && (addr == GLOBAL_SPACE_SIZE_ADDR);
    assign global_alloc_reg_write = global_alloc_reg_hit && write_cycle;
    // only the low byte is kept; the high data byte is ignored
    assign global_alloc_reg_data = data_in[7:0];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            global_alloc_reg <= GLOBAL_SPACE_SIZE_RESET;
        end else if (global_alloc_reg_write) begin
            global_alloc_reg <= global_alloc_reg_data;
        end
    end

    // registered outputs, one short process each; reset parks both memories
    // deselected with both strobes high, so nothing is driven or written

    // the word address; for data the region sits in the two top bits, program holds bit 16 low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sram_addr <= '0;
        end else begin
            sram_addr <= next_sram_addr;
        end
    end

    // both byte memories are selected together: one word is a byte from each
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sram_lo_cs_n <= 1'b1;
        end else begin
            sram_lo_cs_n <= next_cs_n;
        end
    end

    // the high byte memory follows the same select as the low byte
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sram_hi_cs_n <= 1'b1;
        end else begin
            sram_hi_cs_n <= next_cs_n;
        end
    end

    // write enable only for a write to an external region
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sram_we_n <= 1'b1;
        end else begin
            sram_we_n <= next_we_n;
        end
    end

    // output enable only for a read from an external region
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sram_oe_n <= 1'b1;
        end else begin
            sram_oe_n <= next_oe_n;
        end
    end

    // no wait state is ever requested: every access completes in one cycle
    // the memories are fast enough that the processor never has to stretch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b1;
        end else begin
            ready <= 1'b1;
        end
    end

    // the decoded space is reported alongside the memory strobes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            access_space <= SPACE_NONE;
        end else begin
            access_space <= next_space;
        end
    end
endmodule

// ---- logic/mem_decode_pkg.sv ----
// constants for the external memory space decoder
package mem_decode_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int SRAM_ADDR_W = 17;
    localparam logic [15:0] GLOBAL_SPACE_SIZE_ADDR = 16'h0005;
    localparam logic [7:0] GLOBAL_SPACE_SIZE_RESET = 8'h00;
    localparam logic [15:0] FLASH_TOP_ADDR = 16'h4000;
    localparam logic [15:0] DATA_EXT_BASE = 16'h8000;
    // sram region selects: a16..a15 upper bits of the 128K word space
    localparam logic [1:0] REGION_PROG = 2'h0;
    localparam logic [1:0] REGION_LOCAL = 2'h2;
    localparam logic [1:0] REGION_GLOBAL = 2'h3;
    typedef enum logic [1:0] {
        SPACE_NONE = 2'b00,
        SPACE_PROG = 2'b01,
        SPACE_DATA = 2'b10,
        SPACE_IO = 2'b11
    } space_t;
endpackage

// ---- logic/space_classifier.sv ----
// classifies the processor strobes into one access space
module space_classifier (
    input wire logic prog_strobe_n,
    input wire logic data_strobe_n,
    input wire logic io_strobe_n,
    output mem_decode_pkg::space_t space
);
    import mem_decode_pkg::*;
    // strobes are exclusive by the processor; priority keeps one answer anyway
    assign space = !prog_strobe_n ? SPACE_PROG :
                   !data_strobe_n ? SPACE_DATA :
                   !io_strobe_n ? SPACE_IO : SPACE_NONE;
endmodule

// ---- testbench/ext_memory_space_decode_properties.sv ----
// decoder port assertions
module mem_decode_checker (input wire logic clock, rst_n, prog_strobe_n, data_strobe_n,
    sram_lo_cs_n, sram_hi_cs_n, sram_we_n, sram_oe_n, ready, input wire logic [15:0] addr,
    input wire logic [16:0] sram_addr, input wire logic [7:0] global_alloc_reg);
    timeunit 1ns;
    timeprecision 1ps;
    import mem_decode_pkg::*;
    wire idle = prog_strobe_n && data_strobe_n;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_no_wait: assert property (ready) else $error("ready low");
    a_byte_pair: assert property (sram_lo_cs_n == sram_hi_cs_n) else $error("cs split");
    a_no_space: assert property (idle |=> sram_lo_cs_n) else $error("idle select");
    a_reg_hold: assert property (idle |=> $stable(global_alloc_reg)) else $error("reg moved");
    a_we_oe: assert property (!sram_lo_cs_n |-> sram_we_n ^ sram_oe_n) else $error("strobes");
    a_low_data: assert property (prog_strobe_n && !addr[15] |=> sram_lo_cs_n)
        else $error("low data");
    a_local_map: assert property (!data_strobe_n && addr[15] && !global_alloc_reg
        |=> sram_addr[16:15] == 2'h2) else $error("local");
    a_prog_map: assert property (!prog_strobe_n && addr > FLASH_TOP_ADDR
        |=> !sram_lo_cs_n && sram_addr == {1'b0, $past(addr)}) else $error("prog");
endmodule
bind ext_memory_space_decode mem_decode_checker u_mem_decode_checker (.*);

// ---- testbench/ext_memory_space_decode_tb.sv ----
// bench for the memory space decoder
module ext_memory_space_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mem_decode_pkg::*;
    logic clock = 0, rst_n = 0, mode = 1, sram_lo_cs_n, sram_we_n, sram_oe_n;
    logic prog_strobe_n, data_strobe_n, io_strobe_n, read_not_write, write_strobe_n;
    logic sram_hi_cs_n, ready;
    logic [1:0] access_space;
    logic [15:0] addr, data_in;
    logic [16:0] sram_addr;
    logic [7:0] global_alloc_reg;
    int bad_count = 0, n_compared = 0;
    always #4 clock = ~clock;
    proc_bus_model u_proc_bus_model (.*);
    ext_memory_space_decode u_ext_memory_space_decode (.*, .proc_mode_select(mode));
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // e packs cs_n, we_n, oe_n, region; any refused access reads 1C
    task automatic acc(input logic [2:0] sp, input logic [15:0] a, d, input logic [7:0] e);
        logic [7:0] seen, sp_exp;
        sp_exp = sp[2] ? 8'(SPACE_PROG) : sp[1] ? 8'(SPACE_DATA) : 8'(SPACE_IO);
        u_proc_bus_model.cyc(sp, a, d);
        seen = sram_lo_cs_n ? 8'h1C : {3'h0, sram_lo_cs_n, sram_we_n, sram_oe_n,
            sram_addr[16:15]};
        chk("decode", seen, e);
        chk("hi_cs", {7'h0, sram_hi_cs_n}, {7'h0, e[4]});
        chk("ready", {7'h0, ready}, 8'h01);
        chk("space", {6'h0, access_space}, sp_exp);
    endtask
    task automatic t_prog;
        acc(3'h4, 16'h0000, 16'h0, 8'h08);
        mode = 0;
        repeat (3) @(posedge clock);
        acc(3'h4, 16'h4000, 16'h0, 8'h1C);
        acc(3'h4, 16'h4001, 16'h0, 8'h08);
    endtask
    task automatic t_data;
        acc(3'h2, 16'h7FFF, 16'h1234, 8'h1C);
        acc(3'h2, 16'h8000, 16'h5555, 8'h06);
        acc(3'h1, 16'h8000, 16'h5555, 8'h1C);
        acc(3'h2, GLOBAL_SPACE_SIZE_ADDR, 16'hAB80, 8'h1C);
        chk("alloc", global_alloc_reg, 8'h80);
        acc(3'h2, 16'h8000, 16'h1234, 8'h07);
        acc(3'h2, GLOBAL_SPACE_SIZE_ADDR, 16'h00FF, 8'h1C);
        acc(3'h2, 16'hFEFF, 16'h0, 8'h0A);
        acc(3'h2, 16'hFF00, 16'h0, 8'h0B);
    endtask
    task automatic conclude;
        if (bad_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        #1 rst_n = 1;
        t_prog();
        t_data();
        conclude();
    end
endmodule

// ---- testbench/proc_bus_model.sv ----
// processor bus: zero-wait accesses, strobes idle high
module proc_bus_model (input wire logic clock, output logic [15:0] addr, data_in,
    output wire logic prog_strobe_n, data_strobe_n, io_strobe_n, read_not_write, write_strobe_n);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] s;
    assign {prog_strobe_n, data_strobe_n, io_strobe_n, read_not_write, write_strobe_n} = s;
    initial {s, addr, data_in} = {5'h1F, 32'h0};
    // one-hot sp picks prog, data or io; nonzero d writes; bus inverted once released
    task automatic cyc(input logic [2:0] sp, input logic [15:0] a, d);
        @(posedge clock);
        #1 {s, addr, data_in} = {~sp, {2{d == 16'h0}}, a, d};
        @(posedge clock);
        #1 {s, addr, data_in} = {5'h1F, ~a, ~d};
    endtask
endmodule
